// ### rtl/idm_map.vh
// address map, reset values, field positions and command codes of the internal data memory
`ifndef IDM_MAP_VH
`define IDM_MAP_VH

// ---------------------------------------------------------------
// data memory geometry
// ---------------------------------------------------------------
`define IDM_UPPER_BASE 8'h80
`define IDM_BITRAM_BASE 8'h20
`define IDM_BANK_BASE 8'h00

// ---------------------------------------------------------------
// locally held peripheral registers
// ---------------------------------------------------------------
`define IDM_STACK_PTR_ADDR 8'h81
`define IDM_STACK_PTR_RST 8'h07
`define IDM_STATUS_ADDR 8'hd0
`define IDM_STATUS_RST 8'h00
`define IDM_STATUS_BANK_LO 3
`define IDM_STATUS_BANK_HI 4

// ---------------------------------------------------------------
// request kinds from the core
// ---------------------------------------------------------------
`define IDM_OP_DIRECT 2'h0
`define IDM_OP_INDIRECT 2'h1
`define IDM_OP_PUSH 2'h2
`define IDM_OP_POP 2'h3

// ---------------------------------------------------------------
// target of an access
// ---------------------------------------------------------------
`define IDM_TGT_RAM 2'h0
`define IDM_TGT_STACK 2'h1
`define IDM_TGT_STATUS 2'h2
`define IDM_TGT_EXT 2'h3

`endif

// ### rtl/idm_ram.v
// single-port byte storage with registered read data
`timescale 1ns/10ps
`default_nettype none

module idm_ram #(
  parameter AW = 8,
  parameter DW = 8
) (
  // clock
  input wire sys_clk,
  // access
  input wire we,
  input wire [AW-1:0] addr,
  input wire [DW-1:0] wdata,
  // read data, one cycle after the address
  output reg [DW-1:0] rdata
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  // write-first is not needed: the owner never reads a byte it writes in the same cycle
  always @(posedge sys_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule
`default_nettype wire

// ### rtl/idm_data_memory.v
// internal data memory: ram, register banks, bit region, stack pointer and space routing
`timescale 1ns/10ps
`include "idm_map.vh"
`default_nettype none

module idm_data_memory (
  // clock and reset
  input wire sys_clk,
  input wire resetn,
  // request from the core
  input wire req_valid,
  input wire [1:0] req_op,
  input wire req_write,
  input wire req_bit,
  input wire req_ptr_sel,
  input wire [7:0] req_addr,
  input wire [7:0] req_wdata,
  input wire req_wbit,
  output reg req_ready,
  // answer to the core
  output reg rsp_valid,
  output reg [7:0] rsp_rdata,
  output reg rsp_rbit,
  // external peripheral register port
  output reg periph_rd,
  output reg periph_wr,
  output reg [7:0] periph_addr,
  output reg [7:0] periph_wdata,
  input wire [7:0] periph_rdata,
  // state seen by the core
  output reg [7:0] stack_pointer,
  output reg [7:0] program_status_word
);

  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  localparam S_IDLE = 3'h0;
  localparam S_PTR = 3'h1;
  localparam S_PTRW = 3'h2;
  localparam S_ACC = 3'h3;
  localparam S_MRG = 3'h4;

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [1:0] op_ff;
  reg [1:0] nxt_op;
  reg write_ff;
  reg nxt_write;
  reg bit_ff;
  reg nxt_bit;
  reg [2:0] pos_ff;
  reg [2:0] nxt_pos;
  reg [7:0] wdata_ff;
  reg [7:0] nxt_wdata;
  reg wbit_ff;
  reg nxt_wbit;
  reg [7:0] tgt_ff;
  reg [7:0] nxt_tgt;
  reg [1:0] kind_ff;
  reg [1:0] nxt_kind;
  reg [7:0] stk_ptr_ff;
  reg [7:0] nxt_stk_ptr;
  reg [7:0] status_ff;
  reg [7:0] nxt_status;

  // next values of the output flops
  reg nxt_ready;
  reg nxt_rsp_valid;
  reg [7:0] nxt_rsp_rdata;
  reg nxt_rsp_rbit;
  reg nxt_periph_rd;
  reg nxt_periph_wr;
  reg [7:0] nxt_periph_addr;
  reg [7:0] nxt_periph_wdata;

  // decode helpers
  wire [1:0] bank;
  wire [7:0] bit_byte;
  wire [7:0] dir_byte;
  wire [1:0] dir_kind;
  wire [7:0] ptr_loc;
  wire [7:0] stk_inc;
  reg [7:0] rd_val;
  reg [7:0] merged;

  // ram port
  wire mem_we;
  wire [7:0] mem_rdata;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // active bank straight from the status word
  assign bank = {status_ff[`IDM_STATUS_BANK_HI], status_ff[`IDM_STATUS_BANK_LO]};

  // bit address to its byte: low half into 0x20..0x2f, high half onto an x0/x8 register
  assign bit_byte = req_addr[7] ? {req_addr[7:3], 3'h0} :
                    (`IDM_BITRAM_BASE | {4'h0, req_addr[6:3]});

  // operand type decides bit or byte access
  assign dir_byte = req_bit ? bit_byte : req_addr;

  // direct above 0x7f never reaches upper ram
  assign dir_kind = (dir_byte < `IDM_UPPER_BASE) ? `IDM_TGT_RAM :
                    (dir_byte == `IDM_STACK_PTR_ADDR) ? `IDM_TGT_STACK :
                    (dir_byte == `IDM_STATUS_ADDR) ? `IDM_TGT_STATUS : `IDM_TGT_EXT;

  // register 0 or 1 of the active bank holds the pointer
  assign ptr_loc = `IDM_BANK_BASE | {3'h0, bank, 2'h0, req_ptr_sel};

  // push target is one above the last used location
  assign stk_inc = stk_ptr_ff + 8'h01;

  // ---------------------------------------------------------------
  // read data and merge
  // ---------------------------------------------------------------
  // one mux for every source so bit and byte paths share the merge
  always @* begin
    case (kind_ff)
      `IDM_TGT_RAM: begin
        rd_val = mem_rdata;
      end
      `IDM_TGT_STACK: begin
        rd_val = stk_ptr_ff;
      end
      `IDM_TGT_STATUS: begin
        rd_val = status_ff;
      end
      default: begin
        rd_val = periph_rdata;
      end
    endcase
    // a bit write rewrites the whole byte with one bit replaced
    if (bit_ff) begin
      merged = (rd_val & ~(8'h01 << pos_ff)) | ({7'h00, wbit_ff} << pos_ff);
    end else begin
      merged = wdata_ff;
    end
  end

  // ram write only on the merge cycle of a ram target
  assign mem_we = (state_ff == S_MRG) && write_ff && (kind_ff == `IDM_TGT_RAM);

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always @* begin
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_write = write_ff;
    nxt_bit = bit_ff;
    nxt_pos = pos_ff;
    nxt_wdata = wdata_ff;
    nxt_wbit = wbit_ff;
    nxt_tgt = tgt_ff;
    nxt_kind = kind_ff;
    nxt_stk_ptr = stk_ptr_ff;
    nxt_status = status_ff;
    nxt_rsp_valid = 1'b0;
    nxt_rsp_rdata = rsp_rdata;
    nxt_rsp_rbit = rsp_rbit;
    nxt_periph_rd = 1'b0;
    nxt_periph_wr = 1'b0;
    nxt_periph_addr = periph_addr;
    nxt_periph_wdata = periph_wdata;
    case (state_ff)
      S_IDLE: begin
        // ready is still low on the first edge after reset; a request there is refused
        if (req_valid && req_ready) begin
          nxt_op = req_op;
          nxt_write = req_write;
          nxt_bit = 1'b0;
          nxt_pos = req_addr[2:0];
          nxt_wdata = req_wdata;
          nxt_wbit = req_wbit;
          nxt_kind = `IDM_TGT_RAM;
          case (req_op)
            `IDM_OP_DIRECT: begin
              nxt_bit = req_bit;
              nxt_tgt = dir_byte;
              nxt_kind = dir_kind;
              nxt_periph_rd = (dir_kind == `IDM_TGT_EXT);
              nxt_periph_addr = dir_byte;
              nxt_state = S_ACC;
            end
            `IDM_OP_INDIRECT: begin
              // pointer fetch first; the byte it names is fetched after
              nxt_tgt = ptr_loc;
              nxt_state = S_PTR;
            end
            `IDM_OP_PUSH: begin
              nxt_write = 1'b1;
              nxt_tgt = stk_inc;
              nxt_state = S_ACC;
            end
            default: begin
              nxt_write = 1'b0;
              nxt_tgt = stk_ptr_ff;
              nxt_state = S_ACC;
            end
          endcase
        end
      end
      S_PTR: begin
        // ram is reading the pointer register this cycle
        nxt_state = S_PTRW;
      end
      S_PTRW: begin
        // any pointer value, upper half included, lands in ram
        nxt_tgt = mem_rdata;
        nxt_kind = `IDM_TGT_RAM;
        nxt_state = S_ACC;
      end
      S_ACC: begin
        // target byte is being read; also needed before a bit write
        nxt_state = S_MRG;
      end
      S_MRG: begin
        nxt_rsp_valid = 1'b1;
        nxt_rsp_rdata = rd_val;
        nxt_rsp_rbit = rd_val[pos_ff];
        if (write_ff) begin
          case (kind_ff)
            `IDM_TGT_STACK: begin
              nxt_stk_ptr = merged;
            end
            `IDM_TGT_STATUS: begin
              nxt_status = merged;
            end
            `IDM_TGT_EXT: begin
              nxt_periph_wr = 1'b1;
              nxt_periph_wdata = merged;
            end
            default: begin
              nxt_periph_wr = 1'b0;
            end
          endcase
        end
        // pointer moves only after the stack byte has been handled
        if (op_ff == `IDM_OP_PUSH) begin
          nxt_stk_ptr = tgt_ff;
        end else if (op_ff == `IDM_OP_POP) begin
          nxt_stk_ptr = stk_ptr_ff - 8'h01;
        end
        nxt_state = S_IDLE;
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
    nxt_ready = (nxt_state == S_IDLE);
  end

  // ---------------------------------------------------------------
  // state and output flops
  // ---------------------------------------------------------------
  // every output is a flop so the core sees clean, glitch-free timing
  always @(posedge sys_clk) begin
    if (!resetn) begin
      state_ff <= S_IDLE;
      op_ff <= `IDM_OP_DIRECT;
      write_ff <= 1'b0;
      bit_ff <= 1'b0;
      pos_ff <= 3'h0;
      wdata_ff <= 8'h00;
      wbit_ff <= 1'b0;
      tgt_ff <= 8'h00;
      kind_ff <= `IDM_TGT_RAM;
      stk_ptr_ff <= `IDM_STACK_PTR_RST;
      status_ff <= `IDM_STATUS_RST;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
      rsp_rbit <= 1'b0;
      periph_rd <= 1'b0;
      periph_wr <= 1'b0;
      periph_addr <= 8'h00;
      periph_wdata <= 8'h00;
      stack_pointer <= `IDM_STACK_PTR_RST;
      program_status_word <= `IDM_STATUS_RST;
    end else begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      write_ff <= nxt_write;
      bit_ff <= nxt_bit;
      pos_ff <= nxt_pos;
      wdata_ff <= nxt_wdata;
      wbit_ff <= nxt_wbit;
      tgt_ff <= nxt_tgt;
      kind_ff <= nxt_kind;
      stk_ptr_ff <= nxt_stk_ptr;
      status_ff <= nxt_status;
      req_ready <= nxt_ready;
      rsp_valid <= nxt_rsp_valid;
      rsp_rdata <= nxt_rsp_rdata;
      rsp_rbit <= nxt_rsp_rbit;
      periph_rd <= nxt_periph_rd;
      periph_wr <= nxt_periph_wr;
      periph_addr <= nxt_periph_addr;
      periph_wdata <= nxt_periph_wdata;
      stack_pointer <= nxt_stk_ptr;
      program_status_word <= nxt_status;
    end
  end

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  // one array for all 256 bytes; upper half is never on the peripheral path
  idm_ram #(
    .AW(8),
    .DW(8)
  ) u_ram (
    .sys_clk(sys_clk),
    .we(mem_we),
    .addr(tgt_ff),
    .wdata(merged),
    .rdata(mem_rdata)
  );

endmodule
`default_nettype wire

// ### verification/idm_data_memory_sva.sv
// assertion checker for the internal data memory ports
`timescale 1ns/10ps
`default_nettype none
module idm_data_memory_sva (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // core side
  input wire logic req_valid,
  input wire logic [1:0] req_op,
  input wire logic req_bit,
  input wire logic [7:0] req_addr,
  input wire logic req_ready,
  input wire logic rsp_valid,
  // peripheral side and state
  input wire logic periph_rd,
  input wire logic periph_wr,
  input wire logic [7:0] periph_addr,
  input wire logic [7:0] stack_pointer,
  input wire logic [7:0] program_status_word
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // accepted requests; the two local registers never reach the port
  wire take = req_valid && req_ready;
  wire dtake = take && req_op == 2'h0 && req_addr[7];
  wire ext = req_addr != 8'h81 && req_addr != 8'hd0;
  sequence s_short;
    !rsp_valid ##1 !rsp_valid ##1 rsp_valid;
  endsequence
  sequence s_long;
    !rsp_valid [*4] ##1 rsp_valid;
  endsequence
  a_short_answer: assert property (take && req_op != 2'h1 |=> s_short)
    else $error("direct or stack answer off time");
  a_long_answer: assert property (take && req_op == 2'h1 |=> s_long)
    else $error("indirect answer off time");
  a_busy_after: assert property (take |=> !req_ready)
    else $error("ready stayed high after accept");
  a_push_step: assert property (take && req_op == 2'h2 |-> ##3 stack_pointer == $past(stack_pointer, 3) + 8'h01)
    else $error("push did not raise pointer");
  a_pop_step: assert property (take && req_op == 2'h3 |-> ##3 stack_pointer == $past(stack_pointer, 3) - 8'h01)
    else $error("pop did not lower pointer");
  a_periph_route: assert property (dtake && !req_bit && ext |=> periph_rd && periph_addr == $past(req_addr))
    else $error("direct upper byte not sent out");
  a_bit_route: assert property (dtake && req_bit && req_addr[7:3] != 5'h1a |=>
    periph_rd && periph_addr == ($past(req_addr) & 8'hf8))
    else $error("bit access hit wrong register");
  a_no_ram_leak: assert property (periph_rd |-> $past(dtake))
    else $error("peripheral read without direct access");
  a_refuse_busy: assert property (!req_ready |=> !periph_rd)
    else $error("request taken while not ready");
  a_write_late: assert property (periph_wr |-> rsp_valid && $past(periph_rd, 2))
    else $error("peripheral write not read first");
  a_reset_state: assert property ($rose(resetn) |-> stack_pointer == 8'h07 && program_status_word == 8'h00)
    else $error("reset state wrong");
endmodule
bind idm_data_memory idm_data_memory_sva i_idm_data_memory_sva (.sys_clk, .resetn, .req_valid, .req_op, .req_bit,
  .req_addr, .req_ready, .rsp_valid, .periph_rd, .periph_wr, .periph_addr, .stack_pointer, .program_status_word);
`default_nettype wire

// ### verification/idm_sfr_model.sv
// behavioural peripheral register space on the external port
`timescale 1ns/10ps
`default_nettype none
module idm_periph_model (
  // clock
  input wire logic sys_clk,
  // access from the block
  input wire logic periph_rd,
  input wire logic periph_wr,
  input wire logic [7:0] periph_addr,
  input wire logic [7:0] periph_wdata,
  output var logic [7:0] periph_rdata = 8'h00
);
  logic [7:0] regs [0:127] = '{default: 8'h00};
  // data valid only after a strobe; it churns otherwise so stale data never passes
  always @(posedge sys_clk) begin
    if (periph_rd) periph_rdata <= regs[periph_addr[6:0]];
    else periph_rdata <= ~periph_rdata;
    if (periph_wr) regs[periph_addr[6:0]] <= periph_wdata;
  end
endmodule
`default_nettype wire

// ### verification/idm_data_memory_tb.sv
// self-checking bench for the internal data memory
`timescale 1ns/10ps
`default_nettype none
module idm_data_memory_tb;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic req_bit = 1'b0;
  logic req_ptr_sel = 1'b0;
  logic req_wbit = 1'b0;
  logic [1:0] req_op = 2'h0;
  logic [7:0] req_addr = 8'h00;
  logic [7:0] req_wdata = 8'h00;
  wire req_ready, rsp_valid, rsp_rbit, periph_rd, periph_wr;
  wire [7:0] rsp_rdata, periph_addr, periph_wdata, periph_rdata, stack_pointer, program_status_word;
  int fails = 0;
  int comparisons = 0;
  int b;
  always #12.5 sys_clk = ~sys_clk;
  idm_data_memory i_idm_data_memory (.sys_clk, .resetn, .req_valid, .req_op, .req_write, .req_bit, .req_ptr_sel,
    .req_addr, .req_wdata, .req_wbit, .req_ready, .rsp_valid, .rsp_rdata, .rsp_rbit, .periph_rd, .periph_wr,
    .periph_addr, .periph_wdata, .periph_rdata, .stack_pointer, .program_status_word);
  idm_periph_model i_idm_periph_model (.sys_clk, .periph_rd, .periph_wr, .periph_addr, .periph_wdata, .periph_rdata);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one request; pointer select and bit value ride on address and data bit 0
  task automatic acc(input logic [1:0] op, input logic wr, input logic bt, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(negedge sys_clk);
    req_valid = 1'b1;
    req_op = op;
    req_write = wr;
    req_bit = bt;
    req_ptr_sel = a[0];
    req_addr = a;
    req_wdata = d;
    req_wbit = d[0];
    // ready is a flop, so its value here is what the next rising edge samples
    while (req_ready !== 1'b1) @(negedge sys_clk);
    @(posedge sys_clk);
    @(negedge sys_clk);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 8) begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 8) begin
      fails++;
      $display("[FAIL] %0t no answer", $time);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(2'h0, 1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    acc(2'h0, 1'b0, 1'b0, a, 8'h00);
    chk(rsp_rdata, exp);
  endtask
  task automatic summarize;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (20) @(negedge sys_clk);
    resetn = 1'b1;
    @(negedge sys_clk);
    chk(stack_pointer, 8'h07);
    acc(2'h2, 1'b1, 1'b0, 8'h00, 8'h11);
    chk(stack_pointer, 8'h08);
    rd(8'h08, 8'h11);
    acc(2'h3, 1'b0, 1'b0, 8'h00, 8'h00);
    chk(rsp_rdata, 8'h11);
    wr(8'h81, 8'hff);
    rd(8'h81, 8'hff);
    acc(2'h2, 1'b1, 1'b0, 8'h00, 8'h77);
    rd(8'h00, 8'h77);
    acc(2'h3, 1'b0, 1'b0, 8'h00, 8'h00);
    chk(stack_pointer, 8'hff);
    for (b = 0; b < 4; b++) begin
      wr(8'hd0, 8'(b << 3));
      wr(8'(b * 8 + b % 2), 8'h50 + 8'(b));
      wr(8'h50 + 8'(b), 8'hc0 + 8'(b));
      acc(2'h1, 1'b0, 1'b0, 8'(b % 2), 8'h00);
      chk(rsp_rdata, 8'hc0 + 8'(b));
    end
    wr(8'h18, 8'h90);
    acc(2'h1, 1'b1, 1'b0, 8'h00, 8'ha5);
    rd(8'h90, 8'h00);
    wr(8'h90, 8'h5a);
    acc(2'h1, 1'b0, 1'b0, 8'h00, 8'h00);
    chk(rsp_rdata, 8'ha5);
    wr(8'h81, 8'h8f);
    acc(2'h2, 1'b1, 1'b0, 8'h00, 8'h3c);
    acc(2'h1, 1'b0, 1'b0, 8'h00, 8'h00);
    chk(rsp_rdata, 8'h3c);
    wr(8'h22, 8'h00);
    acc(2'h0, 1'b1, 1'b1, 8'h13, 8'h01);
    rd(8'h22, 8'h08);
    wr(8'h2f, 8'h80);
    acc(2'h0, 1'b0, 1'b1, 8'h7f, 8'h00);
    chk({7'h00, rsp_rbit}, 8'h01);
    acc(2'h0, 1'b1, 1'b1, 8'h90, 8'h01);
    rd(8'h90, 8'h5b);
    acc(2'h0, 1'b1, 1'b1, 8'hd4, 8'h00);
    chk(program_status_word, 8'h08);
    // second reset with a push already waiting: ready is low at the first edge, so nothing may be taken
    @(negedge sys_clk);
    resetn = 1'b0;
    req_valid = 1'b1;
    req_op = 2'h2;
    repeat (2) @(negedge sys_clk);
    resetn = 1'b1;
    @(negedge sys_clk);
    req_valid = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk(stack_pointer, 8'h07);
    chk(program_status_word, 8'h00);
    summarize();
  end
  // watchdog, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (4000) @(posedge sys_clk);
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize();
  end
endmodule
`default_nettype wire
